// File: design/fps_top.sv
// suspend/resume control for the self-timed program and erase engine.
// assumes serial pins are async, engine and command decoder are on clk.
`timescale 1ns/1ps

module fps_top import fps_pkg::*; #(
    parameter int SUSP_CYC = SUSP_CYCLES
) (
    // clock and control
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       ce,
    // serial and reset pins
    input  wire logic       spi_cs_n,
    input  wire logic       spi_sck,
    input  wire logic       spi_mosi,
    input  wire logic       hw_reset_n,
    // from command decoder
    input  wire logic       soft_reset,
    input  wire logic       cmd_valid,
    input  wire fps_cmd_t   cmd,
    input  wire logic [PAGE_W-1:0] read_page,
    // from program/erase engine
    input  wire logic       op_start,
    input  wire fps_op_t    op_info,
    input  wire logic       op_done,
    // status
    output logic            prog_paused_buf_one,
    output logic            prog_paused_buf_two,
    output logic            erase_paused_flag,
    output logic            dev_ready,
    // to engine
    output logic            freeze_prog,
    output logic            freeze_erase,
    // command screening
    output logic            cmd_accept,
    output logic            cmd_reject,
    output logic            read_undef,
    // reset losses
    output logic            loss_erase_v,
    output fps_loss_t       loss_erase,
    output logic            loss_prog_v,
    output logic [PAGE_W-1:0] loss_prog_page
);

    generate
        if (SUSP_CYC < 1 || SUSP_CYC > 65535) begin : g_bad
            $error("SUSP_CYC out of range");
        end
    endgenerate

    // ------------------------------------------------------------------
    // pin sampling and edges
    // ------------------------------------------------------------------
    logic [3:0] pins_s;
    logic       cs_s, sck_s, mosi_s, hw_s;
    logic       cs_d_r, sck_d_r, hw_d_r;

    // reset value matches the idle pin levels so no false edge follows reset
    fps_sync #(.W(4), .RST_VAL(4'h9)) u_sync (
        .clk (clk),
        .rst (rst),
        .ce  (ce),
        .d   ({spi_cs_n, spi_sck, spi_mosi, hw_reset_n}),
        .q   (pins_s)
    );

    assign cs_s   = pins_s[3];
    assign sck_s  = pins_s[2];
    assign mosi_s = pins_s[1];
    assign hw_s   = pins_s[0];

    always_ff @(posedge clk) begin
        if (rst) begin
            cs_d_r  <= 1'b1;
            sck_d_r <= 1'b0;
            hw_d_r  <= 1'b1;
        end else if (ce) begin
            cs_d_r  <= cs_s;
            sck_d_r <= sck_s;
            hw_d_r  <= hw_s;
        end
    end

    wire sck_rise = sck_s & ~sck_d_r & ~cs_s;
    wire cs_rise  = cs_s & ~cs_d_r;

    // ------------------------------------------------------------------
    // opcode capture: only the first byte of a frame counts
    // ------------------------------------------------------------------
    logic [2:0] bcnt_r;
    logic [6:0] shreg_r;
    logic [7:0] opc_r;
    logic       opc_got_r;

    wire last_bit = (bcnt_r == 3'(BYTE_BITS - 1));

    always_ff @(posedge clk) begin
        if (rst) begin
            bcnt_r    <= '0;
            shreg_r   <= '0;
            opc_r     <= '0;
            opc_got_r <= 1'b0;
        end else if (ce) begin
            if (cs_s) begin
                bcnt_r    <= '0;
                if (cs_rise == 1'b0)
                    opc_got_r <= 1'b0;
            end else if (sck_rise && !opc_got_r) begin
                shreg_r <= {shreg_r[5:0], mosi_s};
                bcnt_r  <= bcnt_r + 3'h1;
                if (last_bit) begin
                    opc_r     <= {shreg_r, mosi_s};
                    opc_got_r <= 1'b1;
                end
            end
        end
    end

    // acted on at chip select release only
    wire sus_cmd = cs_rise & opc_got_r & (opc_r == OPC_SUSPEND);
    wire res_cmd = cs_rise & opc_got_r & (opc_r == OPC_RESUME);

    // ------------------------------------------------------------------
    // operation tracking and suspend sequencing
    // ------------------------------------------------------------------
    fps_state_t state_r, state_nxt;
    fps_op_t    erase_r, prog_r;
    logic       es_r, ps1_r, ps2_r;
    logic [15:0] cnt_r;

    wire any_ps    = ps1_r | ps2_r;
    wire hw_fall   = ~hw_s & hw_d_r;
    wire abort     = soft_reset | hw_fall;
    // hold everything cleared while the reset pin stays low
    wire clear_all = soft_reset | ~hw_s;
    wire halt_done = (state_r == ST_HALT) && (cnt_r == 16'h0000);

    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            ST_IDLE: begin
                if (op_start)
                    state_nxt = ST_RUN;
                else if (res_cmd && (any_ps || (es_r && !prog_r.valid)))
                    state_nxt = ST_RUN;
            end
            ST_RUN: begin
                if (op_done)
                    state_nxt = ST_IDLE;
                else if (sus_cmd)
                    state_nxt = ST_HALT;
            end
            ST_HALT: begin
                if (halt_done)
                    state_nxt = ST_IDLE;
            end
        endcase
        if (clear_all)
            state_nxt = ST_IDLE;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_r <= ST_IDLE;
            cnt_r   <= '0;
        end else if (ce) begin
            state_r <= state_nxt;
            if (state_r == ST_RUN && sus_cmd && !op_done && !clear_all)
                cnt_r <= 16'(SUSP_CYC - 1);
            else if (cnt_r != 16'h0000)
                cnt_r <= cnt_r - 16'h0001;
        end
    end

    // the program, when present, is always the work that runs first
    always_ff @(posedge clk) begin
        if (rst) begin
            erase_r <= '0;
            prog_r  <= '0;
            es_r    <= 1'b0;
            ps1_r   <= 1'b0;
            ps2_r   <= 1'b0;
        end else if (ce) begin
            if (clear_all) begin
                erase_r <= '0;
                prog_r  <= '0;
                es_r    <= 1'b0;
                ps1_r   <= 1'b0;
                ps2_r   <= 1'b0;
            end else begin
                if (state_r == ST_IDLE && op_start) begin
                    if (op_info.is_erase)
                        erase_r <= op_info;
                    else
                        prog_r  <= op_info;
                end
                // completion wins over a suspend in the same cycle
                if (state_r == ST_RUN && op_done) begin
                    if (prog_r.valid)
                        prog_r.valid  <= 1'b0;
                    else
                        erase_r.valid <= 1'b0;
                end
                if (halt_done) begin
                    if (prog_r.valid && prog_r.buf_two)
                        ps2_r <= 1'b1;
                    else if (prog_r.valid)
                        ps1_r <= 1'b1;
                    else
                        es_r  <= 1'b1;
                end
                if (state_r == ST_IDLE && res_cmd && !op_start) begin
                    if (any_ps) begin
                        ps1_r <= 1'b0;
                        ps2_r <= 1'b0;
                    end else if (!prog_r.valid)
                        es_r  <= 1'b0;
                end
            end
        end
    end

    // suspend outside ST_RUN is not decoded above
    assign prog_paused_buf_one = ps1_r;
    assign prog_paused_buf_two = ps2_r;
    assign erase_paused_flag   = es_r;
    assign dev_ready    = (state_r == ST_IDLE);
    assign freeze_prog  = prog_r.valid & (state_r != ST_RUN);
    assign freeze_erase = erase_r.valid &
                          ((state_r != ST_RUN) | prog_r.valid);

    // ------------------------------------------------------------------
    // command screening during a pause
    // ------------------------------------------------------------------
    wire hit_erase = es_r &&
        (fps_sector(cmd.page) == fps_sector(erase_r.page));
    wire buf_busy  = cmd.buf_two ? ps2_r : ps1_r;
    logic allow;

    always_comb begin
        allow = 1'b1;
        unique case (cmd.cls)
            CMD_READ:         allow = 1'b1;
            CMD_BUF_WRITE:    allow = !buf_busy;
            CMD_PROG_ERASE:   allow = !(es_r || any_ps);
            CMD_PROG_NOERASE: allow = !any_ps && !hit_erase;
            CMD_OTHER:        allow = 1'b1;
            default:          allow = 1'b0;
        endcase
    end

    wire rd_hit = (es_r &&
                   fps_sector(read_page) == fps_sector(erase_r.page)) ||
                  (any_ps &&
                   fps_sector(read_page) == fps_sector(prog_r.page));

    always_ff @(posedge clk) begin
        if (rst) begin
            cmd_accept <= 1'b0;
            cmd_reject <= 1'b0;
            read_undef <= 1'b0;
        end else if (ce) begin
            cmd_accept <= cmd_valid & allow;
            cmd_reject <= cmd_valid & ~allow;
            read_undef <= rd_hit;
        end
    end

    // ------------------------------------------------------------------
    // what a reset destroys while work is paused
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            loss_erase_v   <= 1'b0;
            loss_erase     <= '0;
            loss_prog_v    <= 1'b0;
            loss_prog_page <= '0;
        end else if (ce) begin
            loss_erase_v <= abort & es_r;
            loss_prog_v  <= abort & any_ps;
            if (abort) begin
                loss_erase.sector_wide <= erase_r.sector_wide;
                loss_erase.page        <= erase_r.page;
                loss_prog_page         <= prog_r.page;
            end
        end
    end

endmodule // fps_top

// File: design/fps_pkg.sv
// constants and types for the program/erase suspend block of a serial flash.
// assumes a 100 MHz core clock that samples the serial pins.
//
// Summary of operation
// - suspend is opcode B0h alone; later bytes in that frame are ignored.
// - on chip select release the running program or erase halts within latency.
// - suspending sets buffer 1, buffer 2 or erase paused flag; ready shown.
// - reads into a sector with paused work return undefined data.
// - continuous read gives undefined data while counter sits in paused sector.
// - a program aimed at the erase-paused sector is aborted.
// - during erase pause a program elsewhere may run and be paused too.
// - reset during sector erase pause abandons it; whole sector becomes undefined.
// - reset during page program or page erase pause loses only that page.
// - array and buffer reads of every opcode are accepted during any pause.
// - buffer to memory program with erase is rejected during any pause.
// - buffer to memory program without erase only allowed in erase pause.
// - memory program through buffer with erase rejected in any pause.
// - memory program through buffer without erase only allowed in erase pause.
// - resume is opcode D0h alone; restarts work, clears flag, shows busy.
// - with both paused, first resume restarts the program, next the erase.

package fps_pkg;

    // ------------------------------------------------------------------
    // opcodes and geometry
    // ------------------------------------------------------------------
    localparam logic [7:0] OPC_SUSPEND = 8'hB0;
    localparam logic [7:0] OPC_RESUME  = 8'hD0;
    localparam int         BYTE_BITS   = 8;
    localparam int         PAGE_W      = 12;
    localparam int         SECT_W      = 4;

    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam int T_SUSP_NS     = 20000;
    localparam int SUSP_CYCLES   =
        (T_SUSP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ------------------------------------------------------------------
    // types
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        CMD_READ,
        CMD_BUF_WRITE,
        CMD_PROG_ERASE,
        CMD_PROG_NOERASE,
        CMD_OTHER
    } fps_cls_t;

    typedef struct packed {
        fps_cls_t          cls;
        logic              buf_two;
        logic [PAGE_W-1:0] page;
    } fps_cmd_t;

    typedef struct packed {
        logic              valid;
        logic              is_erase;
        logic              sector_wide;
        logic              buf_two;
        logic [PAGE_W-1:0] page;
    } fps_op_t;

    typedef struct packed {
        logic              sector_wide;
        logic [PAGE_W-1:0] page;
    } fps_loss_t;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_RUN,
        ST_HALT
    } fps_state_t;

    function automatic logic [SECT_W-1:0] fps_sector(
        input logic [PAGE_W-1:0] page);
        return page[PAGE_W-1 -: SECT_W];
    endfunction

endpackage

// File: design/fps_sync.sv
// two flip-flop synchroniser for a group of pin inputs.
// assumes the inputs are asynchronous to clk; reset value is a parameter.
`timescale 1ns/1ps

module fps_sync #(
    parameter int         W       = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    // clock and control
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic         ce,
    // pins in, synchronised out
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    logic [W-1:0] meta_r;

    always_ff @(posedge clk) begin
        if (rst) begin
            meta_r <= RST_VAL;
            q      <= RST_VAL;
        end else if (ce) begin
            meta_r <= d;
            q      <= meta_r;
        end
    end

endmodule // fps_sync

// File: tb/fps_properties.sv
// assertions on the ports of the suspend block.
// assumes a bench with small SUSP_CYC so halts end within 8 cycles.
`timescale 1ns/1ps
module fps_properties import fps_pkg::*; #(
    parameter int SUSP_CYC = SUSP_CYCLES
) (
    // clock and resets
    input wire logic     clk,
    input wire logic     rst,
    input wire logic     hw_reset_n,
    input wire logic     soft_reset,
    // decoder and status
    input wire logic     cmd_valid,
    input wire fps_cmd_t cmd,
    input wire logic     prog_paused_buf_one,
    input wire logic     prog_paused_buf_two,
    input wire logic     erase_paused_flag,
    input wire logic     dev_ready,
    input wire logic     freeze_prog,
    input wire logic     freeze_erase,
    input wire logic     cmd_accept,
    input wire logic     cmd_reject,
    input wire logic     loss_erase_v,
    input wire logic     loss_prog_v
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    wire any_ps = prog_paused_buf_one | prog_paused_buf_two;
    wire halting = (freeze_prog & ~any_ps) |
                   (freeze_erase & ~erase_paused_flag);
    int  halt_n;
    always_ff @(posedge clk) begin
        halt_n <= (rst || !halting) ? 0 : halt_n + 1;
    end
    sequence s_halt;
        !dev_ready [*2];
    endsequence
    sequence s_paused(f);
        dev_ready && f;
    endsequence
    chk_one_answer:
    assert property (cmd_valid |=> cmd_accept ^ cmd_reject)
        else $error("screening gave no single answer");
    chk_no_stray:
    assert property (!cmd_valid |=> !cmd_accept && !cmd_reject)
        else $error("screening answer without request");
    chk_read_ok:
    assert property (cmd_valid && cmd.cls == CMD_READ |=> cmd_accept)
        else $error("read refused during pause");
    chk_erase_prog_rej:
    assert property (cmd_valid && cmd.cls == CMD_PROG_ERASE &&
        (any_ps || erase_paused_flag) |=> cmd_reject)
        else $error("program with erase accepted in pause");
    chk_noerase_rej:
    assert property (cmd_valid && cmd.cls == CMD_PROG_NOERASE &&
        any_ps |=> cmd_reject)
        else $error("program without erase accepted in program pause");
    chk_prog_halt:
    assert property ($rose(freeze_prog) |-> s_halt ##[1:8]
        s_paused(any_ps))
        else $error("program halt did not end paused and ready");
    chk_erase_halt:
    assert property ($rose(freeze_erase) |-> s_halt ##[1:8]
        s_paused(erase_paused_flag))
        else $error("erase halt did not end paused and ready");
    chk_halt_bound:
    assert property (halt_n <= SUSP_CYC + 2)
        else $error("halt latency exceeded");
    chk_resume_busy:
    assert property (disable iff (rst || !hw_reset_n)
        ($fell(prog_paused_buf_one) || $fell(prog_paused_buf_two) ||
        $fell(erase_paused_flag)) && !$past(soft_reset)
        |-> ##[0:1] !dev_ready)
        else $error("flag cleared without busy");
    chk_soft_loss_e:
    assert property (soft_reset && erase_paused_flag |=> loss_erase_v)
        else $error("no erase loss after reset");
    chk_soft_loss_p:
    assert property (soft_reset && any_ps |=> loss_prog_v)
        else $error("no program loss after reset");
endmodule // fps_properties

// File: tb/fps_spi_host.sv
// behavioural host that frames one opcode byte on the serial pins.
// assumes mode 0: sck idles low and toggles only inside a frame.
`timescale 1ns/1ps
module fps_spi_host (
    // serial pins
    output logic spi_cs_n,
    output logic spi_sck,
    output logic spi_mosi
);
    initial begin
        spi_cs_n = 1'b1;
        spi_sck  = 1'b0;
        spi_mosi = 1'b0;
    end
    // opcode alone, then filler bits the device must ignore
    task automatic send(input logic [7:0] op, input int extra);
        logic [15:0] sh;
        sh = {op, ~op};
        spi_cs_n = 1'b0;
        for (int i = 0; i < 8 + extra; i++) begin
            spi_mosi = sh[15 - i];
            #62.5 spi_sck = 1'b1;
            #62.5 spi_sck = 1'b0;
        end
        #62.5 spi_cs_n = 1'b1;
        // released line shows the opposite of its last bit
        spi_mosi = ~spi_mosi;
    endtask
endmodule // fps_spi_host

// File: tb/fps_top_tb.sv
// self-checking bench: host model on the pins, engine and decoder
// pulses from tasks; assumes the checker and host compiled first.
`timescale 1ns/1ps
module fps_top_tb import fps_pkg::*;;
    logic clk, rst, hw_reset_n, soft_reset, cmd_valid, op_start, op_done;
    logic ps1, ps2, es, rdy, frz_p, frz_e, acc, rej, undef, lev, lpv;
    logic e1, e2, ee;
    logic [SECT_W-1:0] esec, psec;
    logic [PAGE_W-1:0] read_page, lpage;
    fps_cmd_t          cmd;
    fps_op_t           op_info;
    fps_loss_t         lerase;
    wire               cs_n, sck, mosi;
    int                n_errors, comparisons, seed;

    fps_spi_host i_host (.spi_cs_n(cs_n), .spi_sck(sck), .spi_mosi(mosi));
    fps_top #(.SUSP_CYC(4)) i_fps_top (
        .clk(clk), .rst(rst), .ce(1'b1), .spi_cs_n(cs_n), .spi_sck(sck),
        .spi_mosi(mosi), .hw_reset_n(hw_reset_n), .soft_reset(soft_reset),
        .cmd_valid(cmd_valid), .cmd(cmd), .read_page(read_page),
        .op_start(op_start), .op_info(op_info), .op_done(op_done),
        .prog_paused_buf_one(ps1), .prog_paused_buf_two(ps2),
        .erase_paused_flag(es), .dev_ready(rdy), .freeze_prog(frz_p),
        .freeze_erase(frz_e), .cmd_accept(acc), .cmd_reject(rej),
        .read_undef(undef), .loss_erase_v(lev), .loss_erase(lerase),
        .loss_prog_v(lpv), .loss_prog_page(lpage));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // ------------------------------------------------------------
    // checks and expectations
    // ------------------------------------------------------------
    task automatic cmp_v(input logic [15:0] g, input logic [15:0] e);
        comparisons++;
        if (g !== e) begin
            n_errors++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic cmp_st(input logic e_rdy);
        cmp_v({ps1, ps2, es, rdy, frz_p, frz_e},
              {e1, e2, ee, e_rdy, e1 | e2, ee});
    endtask
    function automatic logic rej_of(input fps_cmd_t c);
        case (c.cls)
            CMD_BUF_WRITE:    return c.buf_two ? e2 : e1;
            CMD_PROG_ERASE:   return e1 | e2 | ee;
            CMD_PROG_NOERASE: return e1 | e2 |
                (ee && c.page[PAGE_W-1 -: SECT_W] == esec);
            default:          return 1'b0;
        endcase
    endfunction
    function automatic logic undef_of(input logic [PAGE_W-1:0] p);
        return (ee && p[PAGE_W-1 -: SECT_W] == esec) ||
               ((e1 | e2) && p[PAGE_W-1 -: SECT_W] == psec);
    endfunction
    task automatic summarize;
        $display("comparisons %0d errors %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // ------------------------------------------------------------
    // drivers
    // ------------------------------------------------------------
    task automatic screen(input string name);
        fps_cmd_t c;
        for (int i = 0; i < 12; i++) begin
            c.cls = fps_cls_t'(i < 5 ? i : $unsigned($random(seed)) % 5);
            c.buf_two = 1'($random(seed));
            c.page = PAGE_W'($random(seed));
            if (i == 3) c.page[PAGE_W-1 -: SECT_W] = esec;
            @(posedge clk);
            cmd_valid <= 1'b1;
            cmd <= c;
            read_page <= c.page;
            @(posedge clk);
            cmd_valid <= 1'b0;
            #1 cmp_v({acc, rej}, {~rej_of(c), rej_of(c)});
            cmp_v(undef, undef_of(c.page));
        end
        $display("test %s finished", name);
    endtask
    task automatic start_op(input logic er, sw, b2, input logic [11:0] p);
        @(posedge clk);
        op_start <= 1'b1;
        op_info <= '{1'b1, er, sw, b2, p};
        @(posedge clk);
        op_start <= 1'b0;
        #1 cmp_st(1'b0);
    endtask
    task automatic suspend(input int extra);
        i_host.send(OPC_SUSPEND, extra);
        for (int i = 0; i < 40 && rdy !== 1'b1; i++) begin
            @(posedge clk);
            #1;
        end
    endtask
    task automatic resume;
        i_host.send(OPC_RESUME, 0);
        repeat (8) @(posedge clk);
        #1;
    endtask

    initial begin
        repeat (30000) @(posedge clk);
        n_errors++;
        summarize;
    end
    initial begin
        seed = 32'hA14431C4;
        {rst, hw_reset_n, soft_reset, cmd_valid, op_start, op_done} = 6'h30;
        {cmd, op_info, read_page} = '0;
        {e1, e2, ee, esec, psec} = '0;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        repeat (4) @(posedge clk);
        #1 cmp_st(1'b1);
        i_host.send(OPC_SUSPEND, 0);
        repeat (12) @(posedge clk);
        #1 cmp_st(1'b1);
        screen("idle");
        esec = 4'h3;
        start_op(1'b1, 1'b1, 1'b0, 12'h3A5);
        suspend(8);
        ee = 1'b1;
        cmp_st(1'b1);
        screen("erase pause");
        psec = 4'h5;
        start_op(1'b0, 1'b0, 1'b1, 12'h512);
        suspend(0);
        e2 = 1'b1;
        cmp_st(1'b1);
        screen("nested pause");
        resume;
        e2 = 1'b0;
        cmp_st(1'b0);
        @(posedge clk) op_done <= 1'b1;
        @(posedge clk) op_done <= 1'b0;
        #1 cmp_st(1'b1);
        resume;
        ee = 1'b0;
        cmp_st(1'b0);
        suspend(0);
        ee = 1'b1;
        psec = 4'h7;
        start_op(1'b0, 1'b0, 1'b0, 12'h7C0);
        suspend(0);
        e1 = 1'b1;
        cmp_st(1'b1);
        screen("buffer one pause");
        @(posedge clk) soft_reset <= 1'b1;
        @(posedge clk) soft_reset <= 1'b0;
        #1 cmp_v({lev, lpv, lpage}, {2'b11, 12'h7C0});
        cmp_v(lerase, {1'b1, 12'h3A5});
        {e1, ee} = 2'b00;
        @(posedge clk);
        #1 cmp_st(1'b1);
        psec = 4'h9;
        start_op(1'b0, 1'b0, 1'b0, 12'h9E1);
        suspend(0);
        @(posedge clk) hw_reset_n <= 1'b0;
        // the loss pulse stands one cycle: look just after each edge
        for (int i = 0; i < 8 && lpv !== 1'b1; i++) begin
            @(posedge clk);
            #1;
        end
        cmp_v({lpv, lpage}, {1'b1, 12'h9E1});
        repeat (4) @(posedge clk);
        hw_reset_n <= 1'b1;
        repeat (4) @(posedge clk);
        #1 cmp_st(1'b1);
        $display("test resets finished");
        summarize;
    end
endmodule // fps_top_tb

bind fps_top fps_properties #(.SUSP_CYC(SUSP_CYC)) i_fps_properties (
    .clk(clk), .rst(rst), .hw_reset_n(hw_reset_n),
    .soft_reset(soft_reset), .cmd_valid(cmd_valid), .cmd(cmd),
    .prog_paused_buf_one(prog_paused_buf_one),
    .prog_paused_buf_two(prog_paused_buf_two),
    .erase_paused_flag(erase_paused_flag), .dev_ready(dev_ready),
    .freeze_prog(freeze_prog), .freeze_erase(freeze_erase),
    .cmd_accept(cmd_accept), .cmd_reject(cmd_reject),
    .loss_erase_v(loss_erase_v), .loss_prog_v(loss_prog_v));
